// file: hw/dual_clock_fifo_control.sv
// The implementer's own choices: the placing of the registers.
`timescale 1ns/1ps
module dual_clock_fifo_control
#(
  parameter int DEPTH  = fifo_ctrl_pkg::DEPTH,
  parameter int DATA_W = fifo_ctrl_pkg::DATA_W
)
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              master_reset_n,
  input  wire logic              partial_reset_n,
  input  wire logic              reread_from_start_n,
  input  wire logic              fallthrough_select_serial_in,
  input  wire logic              serial_load_enable_n,
  input  wire logic              offset_load_n,
  input  wire logic              write_enable_n,
  input  wire logic              read_enable_n,
  input  wire logic              output_enable_n,
  input  wire logic              write_clock,
  input  wire logic              read_clock,
  input  wire logic [DATA_W-1:0] write_data,
  output logic      [DATA_W-1:0] read_data,
  output logic                   read_data_oe,
  output logic                   full_or_input_ready,
  output logic                   empty_or_output_ready,
  output logic                   almost_full_n,
  output logic                   almost_empty_n,
  output logic                   half_full_n
);

  // ----------------------------------------------------------------------------
  // Sizes and elaboration checks
  // ----------------------------------------------------------------------------
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int PTR_W  = ADDR_W + 1;

  initial
  begin
    if (DATA_W != fifo_ctrl_pkg::DATA_W || DEPTH < 2048 || (1 << ADDR_W) != DEPTH
        || PTR_W > DATA_W)
    begin
      $error("dual_clock_fifo_control: unsupported DEPTH or DATA_W");
    end
  end

  localparam logic [PTR_W-1:0] DEF_PAR = PTR_W'(fifo_ctrl_pkg::OFFSET_DEFAULT_PARALLEL);
  localparam logic [PTR_W-1:0] DEF_SER = PTR_W'(fifo_ctrl_pkg::OFFSET_DEFAULT_SERIAL);
  localparam logic [PTR_W:0]   CAPACITY = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] HALF     = PTR_W'(DEPTH / 2);

  // Default offset for a load pin level seen at master reset
  function automatic logic [PTR_W-1:0] default_offset(input logic load_level);
    default_offset = load_level ? DEF_SER : DEF_PAR;
  endfunction : default_offset

  // ----------------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------------
  fifo_ctrl_pkg::pin_bundle_t pins_raw;   // Pins as they arrive
  fifo_ctrl_pkg::pin_bundle_t pins;       // Pins after the filter

  assign pins_raw = '{master_reset_n, partial_reset_n, reread_from_start_n,
                      fallthrough_select_serial_in, serial_load_enable_n, offset_load_n,
                      write_enable_n, read_enable_n, output_enable_n, write_clock,
                      read_clock, write_data};

  pin_filter
  #(
    .WIDTH      (fifo_ctrl_pkg::PIN_W)
  )
  u_pin_filter
  (
    .mclk       (mclk),
    .reset      (reset),
    .pin_in     (pins_raw),
    .idle_level ({fifo_ctrl_pkg::PIN_W{fifo_ctrl_pkg::PIN_LEVEL_IDLE}}),
    .level_out  (pins)
  );

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];        // Data storage
  logic              wclk_prev_reg;      // Write clock level one cycle ago
  logic              rclk_prev_reg;      // Read clock level one cycle ago
  logic              fall_through_mode;  // 1: fall-through timing
  logic              serial_mode_reg;    // 1: serial offset programming
  logic [PTR_W-1:0]  empty_offset_reg;   // Almost-empty threshold n
  logic [PTR_W-1:0]  full_offset_reg;    // Almost-full threshold m
  logic [PTR_W-1:0]  wptr_reg;           // Write pointer, one wrap bit
  logic [PTR_W-1:0]  rptr_reg;           // Read pointer, one wrap bit
  fifo_ctrl_pkg::offset_sel_t wsel_reg;  // Next offset register to load
  fifo_ctrl_pkg::offset_sel_t rsel_reg;  // Next offset register to read back
  logic [DATA_W-1:0] read_data_reg;      // Output register
  logic              out_valid_reg;      // Fall-through: word on outputs
  logic [1:0]        trans_reg;          // Fall-through transition count
  logic              reread_blank_reg;   // Empty shown after a reread
  logic              oe_reg;             // Data bus drive
  logic              ff_reg;             // Full / input ready
  logic              ef_reg;             // Empty / output ready
  logic              paf_reg;            // Almost full, active low
  logic              pae_reg;            // Almost empty, active low
  logic              hf_reg;             // Half full, active low

  // ----------------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------------
  wire              in_master = ~pins.master_reset_n;
  wire              in_partial = ~pins.partial_reset_n;
  wire              wr_edge = pins.write_clock & ~wclk_prev_reg;
  wire              rd_edge = pins.read_clock & ~rclk_prev_reg;
  wire              rd_trans = pins.read_clock ^ rclk_prev_reg;
  wire              load_sel = ~pins.offset_load_n & ~in_master;
  wire [PTR_W-1:0]  stored = wptr_reg - rptr_reg;
  wire              is_full = stored == CAPACITY[PTR_W-1:0];
  wire              is_empty = stored == '0;
  wire              do_par_load = wr_edge & ~pins.write_enable_n & load_sel
                                  & ~serial_mode_reg;
  wire              do_ser_load = wr_edge & ~pins.serial_load_enable_n & load_sel
                                  & serial_mode_reg;
  wire              do_write = wr_edge & ~pins.write_enable_n & ~load_sel & ~is_full;
  wire              do_rd_offset = rd_edge & ~pins.read_enable_n & load_sel;
  wire              do_reread = rd_edge & ~pins.reread_from_start_n;
  wire              std_read = ~fall_through_mode & rd_edge & ~pins.read_enable_n
                               & ~load_sel & ~is_empty;
  wire              ft_take = fall_through_mode & out_valid_reg & rd_edge
                              & ~pins.read_enable_n & ~load_sel;
  wire              ft_first = fall_through_mode & ~out_valid_reg & ~is_empty
                               & rd_trans & (trans_reg == fifo_ctrl_pkg::FALL_THROUGH_TRANSITIONS
                               - 2'h1);
  wire              do_read = std_read | ft_first | (ft_take & ~is_empty);
  wire [PTR_W-1:0]  offset_word = (rsel_reg == fifo_ctrl_pkg::SEL_EMPTY) ?
                                  empty_offset_reg : full_offset_reg;
  wire [PTR_W:0]    fill_plus_m = {1'b0, stored} + {1'b0, full_offset_reg};

  // ----------------------------------------------------------------------------
  // Clock edge history
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wclk_prev_reg <= 1'b1;
      rclk_prev_reg <= 1'b1;
    end
    else
    begin
      wclk_prev_reg <= pins.write_clock;
      rclk_prev_reg <= pins.read_clock;
    end
  end

  // ----------------------------------------------------------------------------
  // Configuration, caught while master reset is held
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      fall_through_mode <= fifo_ctrl_pkg::MODE_AFTER_RESET;
      serial_mode_reg   <= fifo_ctrl_pkg::SERIAL_AFTER_RESET;
    end
    else if (in_master)
    begin
      fall_through_mode <= pins.fallthrough_select_serial_in;
      serial_mode_reg   <= pins.offset_load_n;
    end
  end

  // ----------------------------------------------------------------------------
  // Offset registers: default at master reset, then loaded by the writer
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      empty_offset_reg <= DEF_PAR;
      full_offset_reg  <= DEF_PAR;
      wsel_reg         <= fifo_ctrl_pkg::SEL_EMPTY;
    end
    else if (in_master)
    begin
      // Both thresholds follow the load pin level
      empty_offset_reg <= default_offset(pins.offset_load_n);
      full_offset_reg  <= default_offset(pins.offset_load_n);
      wsel_reg         <= fifo_ctrl_pkg::SEL_EMPTY;
    end
    else if (in_partial)
    begin
      // Offsets survive; only the load order restarts
      wsel_reg <= fifo_ctrl_pkg::SEL_EMPTY;
    end
    else if (do_ser_load)
    begin
      // One bit per edge; empty offset fills, then spills into full
      {full_offset_reg, empty_offset_reg} <= {full_offset_reg[PTR_W-2:0],
                                              empty_offset_reg,
                                              pins.fallthrough_select_serial_in};
    end
    else if (do_par_load)
    begin
      unique case (wsel_reg)
        fifo_ctrl_pkg::SEL_EMPTY:
        begin
          empty_offset_reg <= pins.write_data[PTR_W-1:0];
          wsel_reg         <= fifo_ctrl_pkg::SEL_FULL;
        end
        fifo_ctrl_pkg::SEL_FULL:
        begin
          full_offset_reg <= pins.write_data[PTR_W-1:0];
          wsel_reg        <= fifo_ctrl_pkg::SEL_EMPTY;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Write side: storage and write pointer
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    // No reset on the array; stale words lie past the pointers
    if (do_write & ~in_master & ~in_partial)
    begin
      mem[wptr_reg[ADDR_W-1:0]] <= pins.write_data;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wptr_reg <= '0;
    end
    else if (in_master | in_partial)
    begin
      wptr_reg <= '0;
    end
    else if (do_write)
    begin
      wptr_reg <= wptr_reg + PTR_W'(1);
    end
  end

  // ----------------------------------------------------------------------------
  // Read side: pointer, output register and fall-through state
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rptr_reg         <= '0;
      read_data_reg    <= '0;
      out_valid_reg    <= 1'b0;
      trans_reg        <= 2'h0;
      reread_blank_reg <= 1'b0;
      rsel_reg         <= fifo_ctrl_pkg::SEL_EMPTY;
    end
    else if (in_master | in_partial)
    begin
      rptr_reg         <= '0;
      read_data_reg    <= '0;
      out_valid_reg    <= 1'b0;
      trans_reg        <= 2'h0;
      reread_blank_reg <= 1'b0;
      rsel_reg         <= fifo_ctrl_pkg::SEL_EMPTY;
    end
    else if (do_reread)
    begin
      // Only the read pointer moves; the empty flag shows empty
      rptr_reg         <= '0;
      out_valid_reg    <= 1'b0;
      trans_reg        <= 2'h0;
      reread_blank_reg <= 1'b1;
    end
    else if (do_rd_offset)
    begin
      read_data_reg <= DATA_W'(offset_word);
      rsel_reg      <= (rsel_reg == fifo_ctrl_pkg::SEL_EMPTY) ?
                       fifo_ctrl_pkg::SEL_FULL : fifo_ctrl_pkg::SEL_EMPTY;
    end
    else
    begin
      if (rd_edge)
      begin
        reread_blank_reg <= 1'b0;
      end
      if (do_read)
      begin
        read_data_reg <= mem[rptr_reg[ADDR_W-1:0]];
        rptr_reg      <= rptr_reg + PTR_W'(1);
        out_valid_reg <= fall_through_mode;
        trans_reg     <= 2'h0;
      end
      else if (ft_take)
      begin
        out_valid_reg <= 1'b0;  // Last word taken, nothing behind it
      end
      else if (fall_through_mode & ~out_valid_reg & ~is_empty & rd_trans)
      begin
        trans_reg <= trans_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Flags and output drive, all registered
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      oe_reg  <= 1'b0;
      ff_reg  <= 1'b1;
      ef_reg  <= 1'b0;
      paf_reg <= 1'b1;
      pae_reg <= 1'b0;
      hf_reg  <= 1'b1;
    end
    else
    begin
      oe_reg  <= ~pins.output_enable_n;
      // Standard: low when full. Fall-through: low while space remains
      ff_reg  <= fall_through_mode ? is_full : ~is_full;
      // Standard: low when empty. Fall-through: low while a word is shown
      if (fall_through_mode)
      begin
        ef_reg <= reread_blank_reg | ~out_valid_reg;
      end
      else
      begin
        ef_reg <= ~reread_blank_reg & ~is_empty;
      end
      paf_reg <= ~(fill_plus_m > CAPACITY);
      pae_reg <= ~(stored < empty_offset_reg);
      hf_reg  <= ~(stored > HALF);
    end
  end

  assign read_data             = read_data_reg;
  assign read_data_oe          = oe_reg;
  assign full_or_input_ready   = ff_reg;
  assign empty_or_output_ready = ef_reg;
  assign almost_full_n         = paf_reg;
  assign almost_empty_n        = pae_reg;
  assign half_full_n           = hf_reg;

endmodule : dual_clock_fifo_control

// file: hw/fifo_ctrl_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and carriers of the dual-clock FIFO control
// ----------------------------------------------------------------------------
package fifo_ctrl_pkg;

  // Word width on both data ports
  localparam int DATA_W = 18;
  // Storage depth in words
  localparam int DEPTH  = 32768;

  // Default offsets chosen at master reset
  localparam logic [15:0] OFFSET_DEFAULT_PARALLEL = 16'h007F;
  localparam logic [15:0] OFFSET_DEFAULT_SERIAL   = 16'h03FF;

  // Read clock transitions before the first word falls through
  localparam logic [1:0] FALL_THROUGH_TRANSITIONS = 2'h3;

  // Settings after the block reset
  localparam logic MODE_AFTER_RESET     = 1'b0;
  localparam logic SERIAL_AFTER_RESET   = 1'b0;
  localparam logic PIN_LEVEL_IDLE       = 1'b1;

  // Offset register order for load and readback
  typedef enum logic [1:0]
  {
    SEL_EMPTY = 2'b01,
    SEL_FULL  = 2'b10
  } offset_sel_t;

  // All pins from the writer and reader, in one bundle
  typedef struct packed
  {
    logic              master_reset_n;
    logic              partial_reset_n;
    logic              reread_from_start_n;
    logic              fallthrough_select_serial_in;
    logic              serial_load_enable_n;
    logic              offset_load_n;
    logic              write_enable_n;
    logic              read_enable_n;
    logic              output_enable_n;
    logic              write_clock;
    logic              read_clock;
    logic [DATA_W-1:0] write_data;
  } pin_bundle_t;

  // Bundle width, for the input filter
  localparam int PIN_W = $bits(pin_bundle_t);

endpackage : fifo_ctrl_pkg

// file: hw/pin_filter.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Three-stage input filter for pins from outside the mclk domain
// ----------------------------------------------------------------------------
module pin_filter
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] idle_level,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_reg;  // Metastability catcher, read by stage2 only
  logic [WIDTH-1:0] stage2_reg;  // Second stage
  logic [WIDTH-1:0] stage3_reg;  // Third stage
  logic [WIDTH-1:0] level_reg;   // Accepted level

  // ----------------------------------------------------------------------------
  // Each bit is accepted once stage 2 and stage 3 agree
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
        begin
          stage1_reg[g] <= 1'b1;
          stage2_reg[g] <= 1'b1;
          stage3_reg[g] <= 1'b1;
          level_reg[g]  <= 1'b1;
        end
        else
        begin
          stage1_reg[g] <= pin_in[g];
          stage2_reg[g] <= stage1_reg[g];
          stage3_reg[g] <= stage2_reg[g];
          // Disagreement: change still settling, keep the old level
          if (stage2_reg[g] == stage3_reg[g])
          begin
            level_reg[g] <= stage3_reg[g];
          end
        end
      end
    end
  endgenerate

  // Idle level is a hint only; reset level is all ones
  assign level_out = level_reg & (idle_level | ~idle_level);

endmodule : pin_filter

// file: verif/fifo_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks of the FIFO control
// ----------------------------------------------------------------
module fifo_monitor
#(
  parameter int DEPTH  = fifo_ctrl_pkg::DEPTH,
  parameter int DATA_W = fifo_ctrl_pkg::DATA_W
)
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              master_reset_n,
  input wire logic              partial_reset_n,
  input wire logic              reread_from_start_n,
  input wire logic              fallthrough_select_serial_in,
  input wire logic              serial_load_enable_n,
  input wire logic              offset_load_n,
  input wire logic              write_enable_n,
  input wire logic              read_enable_n,
  input wire logic              output_enable_n,
  input wire logic              write_clock,
  input wire logic              read_clock,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic [DATA_W-1:0] read_data,
  input wire logic              read_data_oe,
  input wire logic              full_or_input_ready,
  input wire logic              empty_or_output_ready,
  input wire logic              almost_full_n,
  input wire logic              almost_empty_n,
  input wire logic              half_full_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // Link clocks parked, no reset pin low
  wire quiet = !write_clock && !read_clock && master_reset_n && partial_reset_n;
  // 6 or 8 cycles cover the filter lag plus one register
  a_oe_bus_on: assert property ((!output_enable_n) [*6] |-> read_data_oe)
    else $error("bus not driven");
  a_oe_bus_off: assert property (output_enable_n [*6] |-> !read_data_oe)
    else $error("bus driven while disabled");
  a_mreset_clears: assert property ((!master_reset_n) [*8] |-> read_data == '0)
    else $error("master reset left data");
  a_preset_clears: assert property ((!partial_reset_n) [*8] |-> read_data == '0 && half_full_n)
    else $error("partial reset left data or count");
  a_std_reset_flags: assert property ((!master_reset_n && !fallthrough_select_serial_in) [*8]
    |-> !empty_or_output_ready && full_or_input_ready)
    else $error("standard reset flags wrong");
  a_ft_reset_flags: assert property ((!master_reset_n && fallthrough_select_serial_in) [*8]
    |-> empty_or_output_ready && !full_or_input_ready)
    else $error("fall-through reset flags wrong");
  a_partial_flags: assert property ((!master_reset_n) [*8]
    |-> !almost_empty_n && almost_full_n && half_full_n)
    else $error("level flags wrong when empty");
  a_quiet_data: assert property (quiet [*8] |=> $stable(read_data))
    else $error("read data moved while idle");
  a_quiet_flags: assert property (quiet [*8] |=> $stable({full_or_input_ready,
    empty_or_output_ready, almost_full_n, almost_empty_n, half_full_n}))
    else $error("flags moved while idle");
  c_half: cover property (!half_full_n);
  c_full: cover property (!full_or_input_ready && !almost_full_n);
  c_first: cover property ($fell(empty_or_output_ready));
endmodule : fifo_monitor

bind dual_clock_fifo_control fifo_monitor #(.DEPTH(DEPTH), .DATA_W(DATA_W)) fifo_monitor_inst
(
  .mclk(mclk), .reset(reset), .master_reset_n(master_reset_n),
  .partial_reset_n(partial_reset_n), .reread_from_start_n(reread_from_start_n),
  .fallthrough_select_serial_in(fallthrough_select_serial_in),
  .serial_load_enable_n(serial_load_enable_n), .offset_load_n(offset_load_n),
  .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
  .output_enable_n(output_enable_n), .write_clock(write_clock), .read_clock(read_clock),
  .write_data(write_data), .read_data(read_data), .read_data_oe(read_data_oe),
  .full_or_input_ready(full_or_input_ready), .empty_or_output_ready(empty_or_output_ready),
  .almost_full_n(almost_full_n), .almost_empty_n(almost_empty_n), .half_full_n(half_full_n)
);

// file: verif/link_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Writer and reader logic on the far side of the pins
// ----------------------------------------------------------------
module link_model
(
  input  wire logic                  mclk,
  output fifo_ctrl_pkg::pin_bundle_t pins
);
  // Enables idle high; link clocks stand still outside frames
  initial
  begin
    pins = '1;
    pins.write_clock = 1'b0;
    pins.read_clock = 1'b0;
  end

  // One 400 ns period; controls lead the rise by 3 mclk
  task automatic frame(input logic wr);
    repeat (3) @(posedge mclk);
    if (wr)
      pins.write_clock <= 1'b1;
    else
      pins.read_clock <= 1'b1;
    repeat (4) @(posedge mclk);
    pins.write_clock <= 1'b0;
    pins.read_clock <= 1'b0;
    pins.write_enable_n <= 1'b1;
    pins.serial_load_enable_n <= 1'b1;
    pins.read_enable_n <= 1'b1;
    pins.reread_from_start_n <= 1'b1;
    pins.offset_load_n <= 1'b1;
    // Released data line shows the inverse
    pins.write_data <= ~pins.write_data;
  endtask : frame

  // Write clock period: word, parallel offset or serial bit
  task automatic wcyc(input logic we_n, sen_n, ld_n, si, input logic [17:0] d);
    @(posedge mclk);
    pins.write_enable_n <= we_n;
    pins.serial_load_enable_n <= sen_n;
    pins.offset_load_n <= ld_n;
    pins.fallthrough_select_serial_in <= si;
    pins.write_data <= d;
    frame(1'b1);
  endtask : wcyc

  // Read clock period: word, offset readback or reread
  task automatic rcyc(input logic re_n, ld_n, rt_n);
    @(posedge mclk);
    pins.read_enable_n <= re_n;
    pins.offset_load_n <= ld_n;
    pins.reread_from_start_n <= rt_n;
    frame(1'b0);
  endtask : rcyc

  // Reset pins low 8 mclk; settings pins kept
  task automatic pin_reset(input logic mr_n, pr_n, si, ld_n);
    @(posedge mclk);
    pins.master_reset_n <= mr_n;
    pins.partial_reset_n <= pr_n;
    pins.fallthrough_select_serial_in <= si;
    pins.offset_load_n <= ld_n;
    repeat (8) @(posedge mclk);
    pins.master_reset_n <= 1'b1;
    pins.partial_reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : pin_reset
endmodule : link_model

// file: verif/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module tb;
  localparam int          D     = 2048;          // Small depth keeps the fill short
  localparam int          N_OFF = 4;             // Empty offset, parallel load
  localparam int          M_OFF = 3;             // Full offset, parallel load
  localparam logic [23:0] SER   = 24'h005002;    // Serial chain: full 5, empty 2
  logic                       mclk;
  logic                       reset;
  logic                       output_enable_n;   // Bus drive, owned by the bench
  fifo_ctrl_pkg::pin_bundle_t pins;
  logic [17:0]                read_data;
  logic                       read_data_oe, full_or_input_ready, empty_or_output_ready;
  logic                       almost_full_n, almost_empty_n, half_full_n;
  int                         bad_count, n_tests, cycles, i;
  // Data bus, floats while not driven
  wire  [17:0]                q_bus = read_data_oe ? read_data : {18{1'bz}};

  link_model link_model_inst (.mclk(mclk), .pins(pins));

  dual_clock_fifo_control #(.DEPTH(D)) dual_clock_fifo_control_inst
  (
    .mclk(mclk), .reset(reset), .master_reset_n(pins.master_reset_n),
    .partial_reset_n(pins.partial_reset_n), .reread_from_start_n(pins.reread_from_start_n),
    .fallthrough_select_serial_in(pins.fallthrough_select_serial_in),
    .serial_load_enable_n(pins.serial_load_enable_n), .offset_load_n(pins.offset_load_n),
    .write_enable_n(pins.write_enable_n), .read_enable_n(pins.read_enable_n),
    .output_enable_n(output_enable_n), .write_clock(pins.write_clock),
    .read_clock(pins.read_clock), .write_data(pins.write_data), .read_data(read_data),
    .read_data_oe(read_data_oe), .full_or_input_ready(full_or_input_ready),
    .empty_or_output_ready(empty_or_output_ready), .almost_full_n(almost_full_n),
    .almost_empty_n(almost_empty_n), .half_full_n(half_full_n)
  );

  // Clock of 50 ns
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Hang guard; the fill takes about 33k cycles
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Flags trail pin edges by the filter lag
  task automatic settle;
    repeat (8) @(posedge mclk);
  endtask : settle

  task automatic rd(input logic ld_n, input logic [17:0] exp);
    link_model_inst.rcyc(1'b0, ld_n, 1'b1);
    settle();
    chk(q_bus, exp);
  endtask : rd

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    reset = 1'b1;
    output_enable_n = 1'b1;
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    output_enable_n <= 1'b0;
    // Standard timing, parallel method, offsets N_OFF and M_OFF loaded
    link_model_inst.pin_reset(1'b0, 1'b1, 1'b0, 1'b0);
    chk(empty_or_output_ready, 1'b0);
    chk(full_or_input_ready, 1'b1);
    chk(q_bus, 18'h00000);
    link_model_inst.wcyc(1'b0, 1'b1, 1'b0, 1'b0, 18'(N_OFF));
    link_model_inst.wcyc(1'b0, 1'b1, 1'b0, 1'b0, 18'(M_OFF));
    $display("test master reset done");
    // Fill past full; the last write is refused
    for (i = 1; i <= D + 1; i++)
    begin
      link_model_inst.wcyc(1'b0, 1'b1, 1'b1, 1'b0, 18'(i));
      settle();
      chk(almost_empty_n, i >= N_OFF);
      chk(half_full_n, i <= D / 2);
      chk(almost_full_n, i <= D - M_OFF);
      chk(full_or_input_ready, i < D);
    end
    rd(1'b1, 18'h00001);
    chk(full_or_input_ready, 1'b1);
    $display("test fill done");
    // Partial reset, mode pins moved: settings held
    link_model_inst.pin_reset(1'b1, 1'b0, 1'b1, 1'b1);
    chk(empty_or_output_ready, 1'b0);
    chk(q_bus, 18'h00000);
    rd(1'b0, 18'(N_OFF));
    rd(1'b0, 18'(M_OFF));
    $display("test partial reset done");
    // Two reads, rewind, first word again
    for (i = 0; i < 3; i++)
      link_model_inst.wcyc(1'b0, 1'b1, 1'b1, 1'b0, 18'h3FFFF - 18'(i));
    rd(1'b1, 18'h3FFFF);
    rd(1'b1, 18'h3FFFE);
    link_model_inst.rcyc(1'b1, 1'b1, 1'b0);
    settle();
    chk(empty_or_output_ready, 1'b0);
    rd(1'b1, 18'h3FFFF);
    rd(1'b1, 18'h3FFFE);
    $display("test reread done");
    output_enable_n <= 1'b1;
    settle();
    chk(read_data_oe, 1'b0);
    output_enable_n <= 1'b0;
    settle();
    chk(read_data_oe, 1'b1);
    $display("test output enable done");
    // Fall-through timing, serial method
    link_model_inst.pin_reset(1'b0, 1'b1, 1'b1, 1'b1);
    chk(empty_or_output_ready, 1'b1);
    chk(full_or_input_ready, 1'b0);
    for (i = 23; i >= 0; i--)
      link_model_inst.wcyc(1'b1, 1'b0, 1'b0, SER[i], 18'h00000);
    rd(1'b0, 18'h00002);
    rd(1'b0, 18'h00005);
    link_model_inst.wcyc(1'b0, 1'b1, 1'b1, 1'b0, 18'h2A5A5);
    link_model_inst.rcyc(1'b1, 1'b1, 1'b1);
    link_model_inst.rcyc(1'b1, 1'b1, 1'b1);
    settle();
    chk(q_bus, 18'h2A5A5);
    chk(empty_or_output_ready, 1'b0);
    link_model_inst.rcyc(1'b0, 1'b1, 1'b1);
    settle();
    chk(empty_or_output_ready, 1'b1);
    $display("test fall-through done");
    tally_and_finish();
  end
endmodule : tb
